/* File: ccreg_consts.svh */
// Constants for the counter-array register block: special function register
// addresses, field positions and reset values.
// Assumes an 8-bit special function register bus with byte addresses.
`ifndef CCREG_CONSTS_SVH
`define CCREG_CONSTS_SVH

`define CCREG_ADDR_CNT_LOW 8'hF9
`define CCREG_ADDR_CNT_HIGH 8'hFA
`define CCREG_ADDR_M0_LOW 8'hFB
`define CCREG_ADDR_M0_HIGH 8'hFC
`define CCREG_ADDR_M1_LOW 8'hE9
`define CCREG_ADDR_M1_HIGH 8'hEA
`define CCREG_ADDR_M2_LOW 8'hEB
`define CCREG_ADDR_M2_HIGH 8'hEC
`define CCREG_ADDR_M3_LOW 8'hED
`define CCREG_ADDR_M3_HIGH 8'hEE
`define CCREG_ADDR_M4_LOW 8'hFD
`define CCREG_ADDR_M4_HIGH 8'hFE
`define CCREG_ADDR_M5_LOW 8'hCE
`define CCREG_ADDR_M5_HIGH 8'hCF
`define CCREG_BYTE_RESET 8'h00
`define CCREG_MODE_RESET 8'h00
`define CCREG_COMP_EN_BIT 6
`define CCREG_WDOG_MODULE 5
`define CCREG_NUM_MODULES 6

`endif

/* File: ccreg_pkg.sv */
// Types for the counter-array register block.
// Assumes ccreg_consts.svh is included where the numbers are needed.
package ccreg_pkg;

    typedef logic [7:0] ccreg_byte_t;
    typedef logic [15:0] ccreg_word_t;

    // Decoded target of a bus access
    typedef enum logic [1:0] {
        CCREG_TGT_NONE,
        CCREG_TGT_CNT,
        CCREG_TGT_MOD
    } ccreg_tgt_t;

endpackage : ccreg_pkg

/* File: ccreg_mem.sv */
// Small word store for the module compare and auto-reload values.
// Assumes one write port and one read port per cycle, both on clk.
`timescale 1ns/1ps
module ccreg_mem #(
    parameter int DEPTH = 12,
    parameter int AW = 4
) (
    input wire logic clk, // System clock
    input wire logic rst, // Async reset, active high
    input wire logic wr_en, // Byte write strobe
    input wire logic [AW-1:0] wr_addr, // Word index
    input wire logic wr_high, // 1 selects upper byte
    input wire logic [7:0] wr_data, // Byte to store
    input wire logic [AW-1:0] rd_addr, // Word index to read
    output logic [15:0] rd_data // Registered read word
);
    import ccreg_pkg::*;

    // Refuse a store larger than its word index can reach
    if (DEPTH > (1 << AW)) begin : g_bad_depth
        $error("ccreg_mem: DEPTH exceeds address space");
    end

    typedef struct packed {
        logic [DEPTH-1:0][15:0] words;
        logic [15:0] rd_data;
    } ccreg_mem_state_t;

    ccreg_mem_state_t state;
    ccreg_mem_state_t next_state;

    // Byte lane update, then registered read of the old contents
    always_comb begin
        next_state = state;
        if (wr_en && (32'(wr_addr) < DEPTH)) begin
            if (wr_high) begin
                next_state.words[wr_addr][15:8] = wr_data;
            end else begin
                next_state.words[wr_addr][7:0] = wr_data;
            end
        end
        next_state.rd_data = (32'(rd_addr) < DEPTH) ? state.words[rd_addr] : 16'h0000;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign rd_data = state.rd_data;

endmodule : ccreg_mem

/* File: ccreg_top.sv */
// Register access for the counter array: counter bytes with high-byte
// snapshot, watchdog write protection, module compare and auto-reload bytes.
// Assumes a single-cycle special function register bus on clk, same domain.
//
// Contract
// - counter low byte at 0xF9, RW, resets zero
// - counter high reads snapshot taken on low read
// - watchdog enable blocks counter low writes
// - watchdog enable blocks counter high writes
// - six module low bytes, 0xFB to 0xCE
// - six module high bytes, 0xFC to 0xCF
// - auto-reload select steers to reload values
// - low byte write clears comparator enable
// - high byte write sets comparator enable
// - comparator enable is mode bit six
// - watchdog enable protects module five mode
`timescale 1ns/1ps
`include "ccreg_consts.svh"
module ccreg_top #(
    parameter int NUM_MODULES = `CCREG_NUM_MODULES
) (
    input wire logic clk, // System clock, 25 MHz
    input wire logic rst, // Async reset, active high
    input wire logic [7:0] sfr_addr, // Register address
    input wire logic sfr_wr, // Write strobe, one cycle
    input wire logic sfr_rd, // Read strobe, one cycle
    input wire ccreg_pkg::ccreg_byte_t sfr_wdata, // Write data
    input wire logic auto_reload_select, // Steers module bytes to reload
    input wire logic watchdog_enable, // Locks counter and module 5 mode
    input wire logic mode_wr, // Mode register write strobe
    input wire logic [2:0] mode_sel, // Which module mode register
    input wire ccreg_pkg::ccreg_byte_t mode_wdata, // Mode write data
    input wire logic count_inc, // Counter advance from datapath
    output ccreg_pkg::ccreg_byte_t sfr_rdata, // Read data, registered
    output logic sfr_rvalid, // Read data valid pulse
    output ccreg_pkg::ccreg_word_t array_counter_value, // Running counter
    output logic [5:0] comparator_enable, // Per module enable
    output logic [47:0] module_mode_flat // All six mode registers
);
    import ccreg_pkg::*;

    // Decode table and enable fan-out are written for exactly six modules
    if (NUM_MODULES != `CCREG_NUM_MODULES) begin : g_bad_count
        $error("ccreg_top: six modules only");
    end

    typedef struct packed {
        ccreg_word_t counter;
        ccreg_byte_t snapshot;
        logic [5:0][7:0] mode;
        ccreg_byte_t rdata;
        logic rvalid;
        logic rd_mem;
        logic rd_high;
    } ccreg_state_t;

    ccreg_state_t state;
    ccreg_state_t next_state;

    // Decode an address into module index and byte; index 7 means none
    function automatic logic [3:0] mod_decode(input logic [7:0] a);
        unique case (a)
            `CCREG_ADDR_M0_LOW: mod_decode = 4'h0;
            `CCREG_ADDR_M0_HIGH: mod_decode = 4'h8;
            `CCREG_ADDR_M1_LOW: mod_decode = 4'h1;
            `CCREG_ADDR_M1_HIGH: mod_decode = 4'h9;
            `CCREG_ADDR_M2_LOW: mod_decode = 4'h2;
            `CCREG_ADDR_M2_HIGH: mod_decode = 4'hA;
            `CCREG_ADDR_M3_LOW: mod_decode = 4'h3;
            `CCREG_ADDR_M3_HIGH: mod_decode = 4'hB;
            `CCREG_ADDR_M4_LOW: mod_decode = 4'h4;
            `CCREG_ADDR_M4_HIGH: mod_decode = 4'hC;
            `CCREG_ADDR_M5_LOW: mod_decode = 4'h5;
            `CCREG_ADDR_M5_HIGH: mod_decode = 4'hD;
            default: mod_decode = 4'h7;
        endcase
    endfunction : mod_decode

    logic [3:0] dec;
    logic is_mod;
    logic mod_high;
    logic [2:0] mod_idx;
    logic [3:0] mem_idx;
    logic mem_wr;
    logic [15:0] mem_rdata;
    logic cnt_low_hit;
    logic cnt_high_hit;

    // Address decode shared by read and write paths
    always_comb begin
        dec = mod_decode(sfr_addr);
        is_mod = (dec[2:0] != 3'h7);
        mod_high = dec[3];
        mod_idx = dec[2:0];
        // Reload values live in the upper half of the store
        // Widen before adding so module 5 reaches word 11, not a wrapped index
        mem_idx = auto_reload_select ? ({1'b0, mod_idx} + 4'h6) : {1'b0, mod_idx};
        mem_wr = sfr_wr && is_mod;
        cnt_low_hit = (sfr_addr == `CCREG_ADDR_CNT_LOW);
        cnt_high_hit = (sfr_addr == `CCREG_ADDR_CNT_HIGH);
    end

    // Compare and reload bytes; one store keeps the top file small
    ccreg_mem #(
        .DEPTH(12),
        .AW(4)
    ) u_mem (
        .clk(clk),
        .rst(rst),
        .wr_en(mem_wr),
        .wr_addr(mem_idx),
        .wr_high(mod_high),
        .wr_data(sfr_wdata),
        .rd_addr(mem_idx),
        .rd_data(mem_rdata)
    );

    // Counter, snapshot, mode and read pipeline
    always_comb begin
        next_state = state;
        if (count_inc) begin
            next_state.counter = state.counter + 16'h0001;
        end
        // Software load wins over the advance; locked while watchdog runs
        if (sfr_wr && cnt_low_hit && !watchdog_enable) begin
            next_state.counter[7:0] = sfr_wdata;
        end
        if (sfr_wr && cnt_high_hit && !watchdog_enable) begin
            next_state.counter[15:8] = sfr_wdata;
        end
        // Latch upper byte together with the low byte read
        if (sfr_rd && cnt_low_hit) begin
            next_state.snapshot = state.counter[15:8];
        end
        // Mode writes; module 5 frozen while watchdog runs
        if (mode_wr && (mode_sel < 3'h6)) begin
            if (!(watchdog_enable && mode_sel == 3'(`CCREG_WDOG_MODULE))) begin
                next_state.mode[mode_sel] = mode_wdata;
            end
        end
        // Compare byte writes steer the enable; reload writes do not
        if (mem_wr && !auto_reload_select) begin
            if (!(watchdog_enable && mod_idx == 3'(`CCREG_WDOG_MODULE))) begin
                next_state.mode[mod_idx][`CCREG_COMP_EN_BIT] = mod_high;
            end
        end
        // Read answer; module bytes come from the store one cycle later
        next_state.rvalid = sfr_rd;
        next_state.rd_mem = sfr_rd && is_mod;
        next_state.rd_high = mod_high;
        next_state.rdata = 8'h00;
        if (sfr_rd && cnt_low_hit) begin
            next_state.rdata = state.counter[7:0];
        end else if (sfr_rd && cnt_high_hit) begin
            next_state.rdata = state.snapshot;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // Output registers; module read data merged from the store register
    ccreg_byte_t out_rdata;
    logic out_rvalid;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_rdata <= 8'h00;
            out_rvalid <= 1'b0;
        end else begin
            out_rvalid <= state.rvalid;
            out_rdata <= state.rd_mem ? (state.rd_high ? mem_rdata[15:8] : mem_rdata[7:0])
                                      : state.rdata;
        end
    end

    assign sfr_rdata = out_rdata;
    assign sfr_rvalid = out_rvalid;
    assign array_counter_value = state.counter;
    assign module_mode_flat = state.mode;

    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_en
            assign comparator_enable[g] = state.mode[g][`CCREG_COMP_EN_BIT];
        end
    endgenerate

    // Assertions
    // Watchdog lock: a blocked write must leave the byte alone
    a_cnt_low_lock: assert property (@(posedge clk) disable iff (rst)
        sfr_wr && cnt_low_hit && watchdog_enable && !count_inc
        |=> array_counter_value[7:0] == $past(array_counter_value[7:0]))
        else $error("counter low changed while locked");
    a_cnt_high_lock: assert property (@(posedge clk) disable iff (rst)
        sfr_wr && cnt_high_hit && watchdog_enable && !count_inc
        |=> array_counter_value[15:8] == $past(array_counter_value[15:8]))
        else $error("counter high changed while locked");
    // Permitted loads land on the very next edge, ahead of any advance
    a_cnt_low_load: assert property (@(posedge clk) disable iff (rst)
        sfr_wr && cnt_low_hit && !watchdog_enable
        |=> array_counter_value[7:0] == $past(sfr_wdata))
        else $error("counter low not loaded");
    a_cnt_high_load: assert property (@(posedge clk) disable iff (rst)
        sfr_wr && cnt_high_hit && !watchdog_enable
        |=> array_counter_value[15:8] == $past(sfr_wdata))
        else $error("counter high not loaded");
    // Without a load the counter either advances by one or holds
    a_cnt_inc: assert property (@(posedge clk) disable iff (rst)
        count_inc && !(sfr_wr && (cnt_low_hit || cnt_high_hit))
        |=> array_counter_value == 16'($past(array_counter_value) + 16'h0001))
        else $error("counter did not advance");
    a_cnt_hold: assert property (@(posedge clk) disable iff (rst)
        !count_inc && !(sfr_wr && (cnt_low_hit || cnt_high_hit))
        |=> $stable(array_counter_value))
        else $error("counter moved without cause");
    // Back-to-back low then high read must see one counter value
    a_snap_take: assert property (@(posedge clk) disable iff (rst)
        sfr_rd && cnt_low_hit ##1 sfr_rd && cnt_high_hit
        |-> ##2 sfr_rdata == $past(array_counter_value[15:8], 3))
        else $error("snapshot not coherent");
    // Only a low-byte read may refresh the copy; anything else would tear
    a_snap_hold: assert property (@(posedge clk) disable iff (rst)
        !(sfr_rd && cnt_low_hit) |=> $stable(state.snapshot))
        else $error("snapshot changed without low read");
    a_low_read: assert property (@(posedge clk) disable iff (rst)
        sfr_rd && cnt_low_hit |-> ##2 sfr_rvalid && sfr_rdata == $past(array_counter_value[7:0], 2))
        else $error("counter low read wrong");
    // Read answer is a single pulse two edges after the strobe
    a_rvalid_pulse: assert property (@(posedge clk) disable iff (rst)
        sfr_rvalid == $past(sfr_rd, 2))
        else $error("read valid not two cycles after strobe");
    // Idle data lines read zero so a late sampler cannot see stale bytes
    a_rdata_idle: assert property (@(posedge clk) disable iff (rst)
        !sfr_rvalid |-> sfr_rdata == 8'h00)
        else $error("read data not zero while idle");
    a_unmapped_read: assert property (@(posedge clk) disable iff (rst)
        sfr_rd && !is_mod && !cnt_low_hit && !cnt_high_hit |-> ##2 sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    // Compare byte side effects on the enable bit
    a_comp_clear: assert property (@(posedge clk) disable iff (rst)
        mem_wr && !mod_high && !auto_reload_select && mod_idx != 3'h5
        |=> !comparator_enable[$past(mod_idx)])
        else $error("low write did not clear enable");
    a_comp_set: assert property (@(posedge clk) disable iff (rst)
        mem_wr && mod_high && !auto_reload_select && mod_idx != 3'h5 && !mode_wr
        |=> comparator_enable[$past(mod_idx)])
        else $error("high write did not set enable");
    // Module five follows the same side effects once the watchdog is off
    a_comp_clear5: assert property (@(posedge clk) disable iff (rst)
        mem_wr && !mod_high && !auto_reload_select && mod_idx == 3'h5 && !watchdog_enable
        |=> !comparator_enable[5])
        else $error("low write did not clear enable five");
    a_comp_set5: assert property (@(posedge clk) disable iff (rst)
        mem_wr && mod_high && !auto_reload_select && mod_idx == 3'h5 && !watchdog_enable
        && !mode_wr |=> comparator_enable[5])
        else $error("high write did not set enable five");
    // A plain mode write lands whole in its own byte lane
    a_mode_write: assert property (@(posedge clk) disable iff (rst)
        mode_wr && mode_sel < 3'h6 && !(watchdog_enable && mode_sel == 3'h5) && !mem_wr
        |=> module_mode_flat[8 * $past(mode_sel) +: 8] == $past(mode_wdata))
        else $error("mode write did not land");
    a_mode5_lock: assert property (@(posedge clk) disable iff (rst)
        watchdog_enable |=> module_mode_flat[47:40] == $past(module_mode_flat[47:40]))
        else $error("module 5 mode changed while locked");
    // Reload values share the addresses but must not steer the enables
    a_reload_keep: assert property (@(posedge clk) disable iff (rst)
        mem_wr && auto_reload_select && !mode_wr |=> comparator_enable == $past(comparator_enable))
        else $error("reload write touched enable");
    // Main scenarios worth seeing at least once
    c_snap_pair: cover property (@(posedge clk) sfr_rd && cnt_low_hit ##1 sfr_rd && cnt_high_hit);
    c_locked_wr: cover property (@(posedge clk) sfr_wr && cnt_low_hit && watchdog_enable);
    c_reload_wr: cover property (@(posedge clk) mem_wr && auto_reload_select);
    c_comp_on: cover property (@(posedge clk) mem_wr && mod_high && !auto_reload_select);
    c_unmapped_rd: cover property (@(posedge clk) sfr_rd && !is_mod && !cnt_low_hit && !cnt_high_hit);

endmodule : ccreg_top

/* File: ccreg_host.sv */
// Processor-side model of the register bus: single byte reads and writes.
// Assumes the bench calls its tasks; strobes move on falling clock edges.
`timescale 1ns/1ps
module ccreg_host (
    input wire logic clk, // System clock
    output logic [7:0] sfr_addr, // Register address
    output logic sfr_wr, // Write strobe
    output logic sfr_rd, // Read strobe
    output logic [7:0] sfr_wdata // Write data
);
    initial begin
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_wdata = 8'h00;
    end

    // One-cycle strobe; idle lines invert so stale values never look valid
    task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = w;
        sfr_rd = !w;
        @(negedge clk);
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_addr = ~a;
        sfr_wdata = ~d;
    endtask : access

    // Two reads on consecutive edges; strobe held up across both
    task automatic read_pair(input logic [7:0] a1, input logic [7:0] a2);
        @(negedge clk);
        sfr_addr = a1;
        sfr_wr = 1'b0;
        sfr_rd = 1'b1;
        @(negedge clk);
        sfr_addr = a2;
        @(negedge clk);
        sfr_rd = 1'b0;
        sfr_addr = ~a2;
    endtask : read_pair
endmodule : ccreg_host

/* File: tb_top.sv */
// Self-checking bench for the counter-array register block.
// Assumes the host model drives the bus; reads are scored from a queue.
`timescale 1ns/1ps
`include "ccreg_consts.svh"
module tb_top;
    import ccreg_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ars = 1'b0;
    logic wde = 1'b0;
    logic mode_wr = 1'b0;
    logic count_inc = 1'b0;
    logic [2:0] mode_sel = 3'h0;
    logic [7:0] mode_wdata = 8'h00;
    logic [7:0] sfr_addr, sfr_wdata;
    logic sfr_wr, sfr_rd, sfr_rvalid;
    ccreg_byte_t sfr_rdata;
    ccreg_word_t cnt;
    logic [5:0] ce;
    logic [5:0] exp_ce = 6'h00;
    logic [47:0] modes;
    logic [7:0] q[$];
    logic [7:0] lo[6] = '{`CCREG_ADDR_M0_LOW, `CCREG_ADDR_M1_LOW, `CCREG_ADDR_M2_LOW,
        `CCREG_ADDR_M3_LOW, `CCREG_ADDR_M4_LOW, `CCREG_ADDR_M5_LOW};
    logic [7:0] hi[6] = '{`CCREG_ADDR_M0_HIGH, `CCREG_ADDR_M1_HIGH, `CCREG_ADDR_M2_HIGH,
        `CCREG_ADDR_M3_HIGH, `CCREG_ADDR_M4_HIGH, `CCREG_ADDR_M5_HIGH};
    logic [15:0] cmp[12];
    logic [31:0] seed = 32'h0000C9AE;
    logic [31:0] r;
    int n_fail = 0;
    int compares = 0;
    int cyc = 0;
    int i, s;

    always #20 clk = ~clk;

    ccreg_top dut (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .auto_reload_select(ars),
        .watchdog_enable(wde), .mode_wr(mode_wr), .mode_sel(mode_sel),
        .mode_wdata(mode_wdata), .count_inc(count_inc), .sfr_rdata(sfr_rdata),
        .sfr_rvalid(sfr_rvalid), .array_counter_value(cnt), .comparator_enable(ce),
        .module_mode_flat(modes));
    ccreg_host host (.clk(clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic results();
        if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Note the expected byte, then issue the read
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        q.push_back(e);
        host.access(a, 8'h00, 1'b0);
    endtask : rd

    task automatic mode(input logic [2:0] m, input logic [7:0] d);
        @(negedge clk);
        mode_sel = m;
        mode_wdata = d;
        mode_wr = 1'b1;
        @(negedge clk);
        mode_wr = 1'b0;
    endtask : mode

    // Read monitor and hang limit; data settles well before the falling edge
    always @(negedge clk) begin
        cyc++;
        if (cyc > 6000) begin
            n_fail++;
            results();
        end else if (sfr_rvalid === 1'b1) begin
            if (q.size() == 0) chk("unexpected rvalid", 48'h0, 48'h1);
            else chk("sfr_rdata", q.pop_front(), sfr_rdata);
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        // Reset values of the counter and compare bytes (reload bank not read), plus an unmapped address
        rd(`CCREG_ADDR_CNT_LOW, 8'h00);
        rd(`CCREG_ADDR_CNT_HIGH, 8'h00);
        for (i = 0; i < 6; i++) begin
            rd(lo[i], 8'h00);
            rd(hi[i], 8'h00);
        end
        rd(8'h80, 8'h00);
        // Enable all comparators so the clearing side effect is visible
        for (i = 0; i < 6; i++) mode(i[2:0], 8'h40);
        chk("comparator_enable", 48'h3F, {42'h0, ce});
        exp_ce = 6'h3F;
        // Compare bank then reload bank; only the compare bank moves enables
        for (s = 0; s < 2; s++) begin
            ars = s[0];
            for (i = 0; i < 6; i++) begin
                r = xs();
                cmp[i + 6 * s] = r[15:0];
                host.access(lo[i], r[7:0], 1'b1);
                if (s == 0) exp_ce[i] = 1'b0;
                chk("comparator_enable", {42'h0, exp_ce}, {42'h0, ce});
                host.access(hi[i], r[15:8], 1'b1);
                if (s == 0) exp_ce[i] = 1'b1;
                chk("comparator_enable", {42'h0, exp_ce}, {42'h0, ce});
            end
        end
        for (s = 0; s < 2; s++) begin
            ars = s[0];
            for (i = 0; i < 6; i++) begin
                rd(lo[i], cmp[i + 6 * s][7:0]);
                rd(hi[i], cmp[i + 6 * s][15:8]);
            end
        end
        ars = 1'b0;
        // Counter load, one increment across the byte boundary, snapshot reads
        host.access(`CCREG_ADDR_CNT_LOW, 8'hFF, 1'b1);
        chk("counter", 48'h00FF, {32'h0, cnt});
        host.access(`CCREG_ADDR_CNT_HIGH, 8'h12, 1'b1);
        chk("counter", 48'h12FF, {32'h0, cnt});
        @(negedge clk) count_inc = 1'b1;
        @(negedge clk) count_inc = 1'b0;
        chk("counter", 48'h1300, {32'h0, cnt});
        rd(`CCREG_ADDR_CNT_LOW, 8'h00);
        host.access(`CCREG_ADDR_CNT_HIGH, 8'h77, 1'b1);
        rd(`CCREG_ADDR_CNT_HIGH, 8'h13);
        rd(`CCREG_ADDR_CNT_LOW, 8'h00);
        rd(`CCREG_ADDR_CNT_HIGH, 8'h77);
        // Low then high on consecutive edges, as software should read it
        q.push_back(8'h00);
        q.push_back(8'h77);
        host.read_pair(`CCREG_ADDR_CNT_LOW, `CCREG_ADDR_CNT_HIGH);
        // Watchdog lock on counter bytes and on module five
        wde = 1'b1;
        host.access(`CCREG_ADDR_CNT_LOW, 8'h5A, 1'b1);
        chk("counter", 48'h7700, {32'h0, cnt});
        host.access(`CCREG_ADDR_CNT_HIGH, 8'hA5, 1'b1);
        chk("counter", 48'h7700, {32'h0, cnt});
        mode(3'h5, 8'h00);
        chk("mode five", 48'h40, {40'h0, modes[47:40]});
        host.access(lo[5], 8'h3C, 1'b1);
        mode(3'h4, 8'h00);
        chk("comparator_enable", 48'h2F, {42'h0, ce});
        wde = 1'b0;
        mode(3'h5, 8'h00);
        chk("comparator_enable", 48'h0F, {42'h0, ce});
        repeat (4) @(negedge clk);
        if (q.size() != 0) chk("pending reads", 48'h0, 48'(q.size()));
        results();
    end
endmodule : tb_top
